/* File: bench/ufc_dma_model.sv */
// DMA controller stand-in for one request line.
// Assumes req is a pclk level held until acknowledged.
`timescale 1ns/100ps
module ufc_dma_model #(
  parameter int DLY = 0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic req,
  output logic      ack
);
  int cnt;
  // One ack pulse per request, DLY cycles late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ack <= 1'h0;
    end else begin
      ack <= 1'h0;
      if (req && !ack && cnt == DLY) begin
        ack <= 1'h1;
        cnt <= 0;
      end else if (req && !ack) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : ufc_dma_model

/* File: bench/ufc_monitor.sv */
// Port checker for the interrupt, DMA and flow slice.
// Assumes binding into ufc_top on pclk.
`timescale 1ns/100ps
module ufc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_dma_want,
  input wire logic rx_dma_ack,
  input wire logic rx_dma_req,
  input wire logic tx_dma_want,
  input wire logic tx_dma_ack,
  input wire logic tx_dma_req,
  input wire logic tx_halt,
  input wire logic tx_char_boundary,
  input wire logic special_char_hit,
  input wire logic rx_char_valid
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rx_req_hold_a: assert property (rx_dma_req && !rx_dma_ack |=> rx_dma_req)
    else $error("rx request dropped early");
  tx_req_hold_a: assert property (tx_dma_req && !tx_dma_ack |=> tx_dma_req)
    else $error("tx request dropped early");
  rx_ack_drop_a: assert property (rx_dma_req && rx_dma_ack |=> !rx_dma_req [*2])
    else $error("rx request kept after ack");
  rx_req_cause_a: assert property ($rose(rx_dma_req) |-> $past(rx_dma_want))
    else $error("rx request without want");
  tx_req_cause_a: assert property ($rose(tx_dma_req) |-> $past(tx_dma_want))
    else $error("tx request without want");
  halt_cause_a: assert property ($rose(tx_halt) |-> $past(tx_char_boundary))
    else $error("halt off a character boundary");
  hit_cause_a: assert property (special_char_hit |-> $past(rx_char_valid))
    else $error("hit without a character");
endmodule : ufc_monitor

bind ufc_top ufc_monitor mon (
  .pclk             (pclk),
  .presetn          (presetn),
  .psel             (psel),
  .penable          (penable),
  .pready           (pready),
  .pslverr          (pslverr),
  .rx_dma_want      (rx_dma_want),
  .rx_dma_ack       (rx_dma_ack),
  .rx_dma_req       (rx_dma_req),
  .tx_dma_want      (tx_dma_want),
  .tx_dma_ack       (tx_dma_ack),
  .tx_dma_req       (tx_dma_req),
  .tx_halt          (tx_halt),
  .tx_char_boundary (tx_char_boundary),
  .special_char_hit (special_char_hit),
  .rx_char_valid    (rx_char_valid)
);

/* File: bench/ufc_top_test.sv */
// Self-checking bench for ufc_top with two DMA models.
// Assumes the checker is bound into ufc_top.
`timescale 1ns/100ps
module ufc_top_test;
  logic        pclk, presetn, psel, penable, pwrite, rxv, txb, rxw, txw, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [8:0]  ev;
  logic [7:0]  rxc_q;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, rxr, txr, rxa, txa, halt, hit;
  wire  [4:0]  o = {irq, hit, halt, txr, rxr};
  int          n_mismatch = 0;
  int          n_compared = 0;

  ufc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_cts(ev[0]), .evt_rx(ev[1]), .evt_tx(ev[2]), .evt_rx_timeout(ev[3]), .evt_framing_err(ev[4]),
    .evt_parity_err(ev[5]), .evt_break_err(ev[6]), .evt_overrun_err(ev[7]), .evt_tx_fifo_empty(ev[8]),
    .rx_char_valid(rxv), .rx_char(rxc_q), .tx_char_boundary(txb), .rx_dma_want(rxw), .rx_dma_ack(rxa),
    .tx_dma_want(txw), .tx_dma_ack(txa), .irq(irq), .rx_dma_req(rxr), .tx_dma_req(txr),
    .tx_halt(halt), .special_char_hit(hit));
  ufc_dma_model #(.DLY(0)) rxm (.pclk(pclk), .presetn(presetn), .req(rxr), .ack(rxa));
  ufc_dma_model #(.DLY(4)) txm (.pclk(pclk), .presetn(presetn), .req(txr), .ack(txa));

  // Clock at 40 MHz
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  // APB setup then access, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 9);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    if (pready !== 1'h1) begin
      n_mismatch++;
      summarize();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
    apb(1'h0, a, 32'h0);
    chk(s, rd, e);
  endtask : rdc

  // Whether an output went high within n cycles
  task automatic obs(input int k, input int n, input logic e, input string s);
    logic v;
    v = 1'h0;
    repeat (n) begin
      @(posedge pclk);
      if (o[k] === 1'h1) v = 1'h1;
    end
    chk(s, v, e);
  endtask : obs

  task automatic low(input int k, input string s);
    repeat (3) @(posedge pclk);
    chk(s, o[k], 1'h0);
  endtask : low

  task automatic pulse(input int k);
    @(posedge pclk);
    ev <= 9'h1 << k;
    @(posedge pclk);
    ev <= 9'h0;
  endtask : pulse

  task automatic rxc(input logic [7:0] c);
    @(posedge pclk);
    {rxv, rxc_q} <= {1'h1, c};
    @(posedge pclk);
    rxv <= 1'h0;
  endtask : rxc

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdc(12'h040, 32'h0, "masked");
    rdc(12'h048, 32'h0, "dma");
    rdc(12'h050, 32'h0, "flow");
    wr(12'h048, 32'hFFFFFFFF);
    rdc(12'h048, 32'hB, "dma");
    wr(12'h050, 32'hFFFFFFFF);
    rdc(12'h050, 32'h7F, "flow");
    rdc(12'h044, 32'h0, "clear");
    apb(1'h0, 12'h0FC, 32'h0);
    chk("unmapped", err, 1'h1);
    wr(12'h048, 32'h0);
    wr(12'h050, 32'h0);
  endtask : t_regs

  task automatic t_irq;
    int k;
    int p;
    wr(12'h038, 32'h1FF2);
    for (k = 0; k < 9; k++) begin
      p = (k == 0) ? 1 : (k == 8) ? 12 : k + 3;
      pulse(k);
      wr(12'h044, 32'h0);
      rdc(12'h040, 32'h1 << p, "masked");
      chk("irq", irq, 1'h1);
      wr(12'h044, 32'h1 << p);
      rdc(12'h040, 32'h0, "masked");
      chk("irq", irq, 1'h0);
    end
    wr(12'h038, 32'h0);
    pulse(1);
    rdc(12'h040, 32'h0, "masked");
    rdc(12'h03C, 32'h10, "raw");
    chk("irq", irq, 1'h0);
    wr(12'h044, 32'h10);
  endtask : t_irq

  task automatic t_dma;
    rxw <= 1'h1;
    obs(0, 8, 1'h0, "rxreq");
    wr(12'h048, 32'h1);
    obs(0, 20, 1'h1, "rxreq");
    wr(12'h038, 32'h80);
    wr(12'h048, 32'h9);
    pulse(4);
    repeat (4) @(posedge pclk);
    obs(0, 8, 1'h0, "rxreq");
    wr(12'h044, 32'h80);
    obs(0, 20, 1'h1, "rxreq");
    pulse(4);
    wr(12'h048, 32'h1);
    obs(0, 20, 1'h1, "rxreq");
    wr(12'h048, 32'h0);
    rxw <= 1'h0;
    wr(12'h044, 32'h80);
    txw <= 1'h1;
    obs(1, 8, 1'h0, "txreq");
    wr(12'h048, 32'h2);
    obs(1, 20, 1'h1, "txreq");
    txw <= 1'h0;
    wr(12'h048, 32'h0);
  endtask : t_dma

  task automatic t_flow;
    wr(12'h05C, 32'h13);
    wr(12'h054, 32'hFFFFFF11);
    wr(12'h060, 32'h93);
    wr(12'h058, 32'h91);
    rdc(12'h054, 32'h11, "resume1");
    wr(12'h038, 32'h800);
    txb <= 1'h1;
    wr(12'h050, 32'h0B);
    rxc(8'h13);
    obs(2, 8, 1'h1, "halt");
    rdc(12'h040, 32'h800, "masked");
    rxc(8'h93);
    obs(2, 3, 1'h1, "halt");
    rxc(8'h11);
    low(2, "halt");
    wr(12'h050, 32'h2B);
    rxc(8'h13);
    obs(2, 8, 1'h1, "halt");
    rxc(8'h55);
    low(2, "halt");
    wr(12'h044, 32'h800);
    wr(12'h050, 32'h15);
    rxc(8'h13);
    obs(2, 8, 1'h0, "halt");
    txb <= 1'h0;
    rxc(8'h93);
    obs(2, 8, 1'h0, "halt");
    rdc(12'h064, 32'h2, "flow status");
    txb <= 1'h1;
    obs(2, 8, 1'h1, "halt");
    rdc(12'h040, 32'h800, "masked");
    rxc(8'h91);
    low(2, "halt");
    wr(12'h044, 32'h800);
    wr(12'h050, 32'h0A);
    rxc(8'h13);
    obs(2, 8, 1'h0, "halt");
    rdc(12'h040, 32'h0, "masked");
    wr(12'h050, 32'h40);
    rxc(8'h91);
    obs(3, 3, 1'h1, "hit");
    wr(12'h050, 32'h0);
    rxc(8'h91);
    obs(3, 3, 1'h0, "hit");
  endtask : t_flow

  // Reset, then the scenarios in turn
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ev, rxv, rxc_q, txb, rxw, txw} = '0;
    presetn = 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_irq();
    t_dma();
    t_flow();
    summarize();
  end
endmodule : ufc_top_test

/* File: common/ufc_pkg.sv */
// Constants for the serial port interrupt, DMA and soft flow control slice.
// Assumes a 32-bit APB slave with word-aligned registers and byte offsets.
package ufc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_MASK          = 12'h038;
  localparam logic [11:0] OFS_RAW_STATUS    = 12'h03C;
  localparam logic [11:0] OFS_MASKED_STATUS = 12'h040;
  localparam logic [11:0] OFS_INT_CLEAR     = 12'h044;
  localparam logic [11:0] OFS_DMA_CONTROL   = 12'h048;
  localparam logic [11:0] OFS_SOFT_FLOW     = 12'h050;
  localparam logic [11:0] OFS_RESUME_CHAR1  = 12'h054;
  localparam logic [11:0] OFS_RESUME_CHAR2  = 12'h058;
  localparam logic [11:0] OFS_PAUSE_CHAR1   = 12'h05C;
  localparam logic [11:0] OFS_PAUSE_CHAR2   = 12'h060;
  localparam logic [11:0] OFS_FLOW_STATUS   = 12'h064;

  // ---------------------------------------------------------------
  // Interrupt bit positions (status, mask and clear share them)
  // ---------------------------------------------------------------
  localparam int IRQ_W         = 13;
  localparam int BIT_CTS       = 1;
  localparam int BIT_RX        = 4;
  localparam int BIT_TX        = 5;
  localparam int BIT_RX_TMO    = 6;
  localparam int BIT_FRAMING   = 7;
  localparam int BIT_PARITY    = 8;
  localparam int BIT_BREAK     = 9;
  localparam int BIT_OVERRUN   = 10;
  localparam int BIT_PAUSE     = 11;
  localparam int BIT_TX_EMPTY  = 12;
  localparam logic [IRQ_W-1:0] IRQ_IMPL_BITS = 13'h1FF2;

  // ---------------------------------------------------------------
  // DMA control fields
  // ---------------------------------------------------------------
  localparam int BIT_RX_DMA_EN   = 0;
  localparam int BIT_TX_DMA_EN   = 1;
  localparam int BIT_DMA_STOP_ER = 3;
  localparam int DMA_CTRL_W      = 4;
  localparam logic [DMA_CTRL_W-1:0] DMA_CTRL_IMPL = 4'hB;

  // ---------------------------------------------------------------
  // Soft flow control fields
  // ---------------------------------------------------------------
  localparam int BIT_FLOW_EN     = 0;
  localparam int POS_RX_SEL_LO   = 1;
  localparam int POS_TX_SEL_LO   = 3;
  localparam int BIT_ANY_RESUME  = 5;
  localparam int BIT_SPECIAL_EN  = 6;
  localparam int FLOW_CTRL_W     = 7;
  localparam int CHAR_W          = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [IRQ_W-1:0]       RST_IRQ       = 13'h0000;
  localparam logic [DMA_CTRL_W-1:0]  RST_DMA_CTRL  = 4'h0;
  localparam logic [FLOW_CTRL_W-1:0] RST_FLOW_CTRL = 7'h00;
  localparam logic [CHAR_W-1:0]      RST_CHAR      = 8'h00;

endpackage : ufc_pkg

/* File: rtl/ufc_dma_req.sv */
// One DMA request line with acknowledge handshake.
// Assumes want and ack come from logic on the same clock.
`timescale 1ns/100ps
module ufc_dma_req (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic want,
  input  wire logic ack,
  output logic      req
);

  logic hold_off;

  // ---------------------------------------------------------------
  // Request flop
  // ---------------------------------------------------------------
  // Raise only when enabled; stays until acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 1'b0;
    end else if (req && ack) begin
      req <= 1'b0;
    end else if (!req && !hold_off && enable && want) begin
      req <= 1'b1;
    end
  end

  // One idle cycle after ack so a stale want is not seen twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_off <= 1'b0;
    end else begin
      hold_off <= req && ack;
    end
  end

endmodule : ufc_dma_req

/* File: rtl/ufc_top.sv */
// Interrupt status, DMA request and soft flow control slice of a serial port.
// Assumes an APB master on pclk and same-clock event pulses from the rest of the port.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module ufc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        evt_cts,
  input  wire logic        evt_rx,
  input  wire logic        evt_tx,
  input  wire logic        evt_rx_timeout,
  input  wire logic        evt_framing_err,
  input  wire logic        evt_parity_err,
  input  wire logic        evt_break_err,
  input  wire logic        evt_overrun_err,
  input  wire logic        evt_tx_fifo_empty,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        tx_char_boundary,
  input  wire logic        rx_dma_want,
  input  wire logic        rx_dma_ack,
  input  wire logic        tx_dma_want,
  input  wire logic        tx_dma_ack,
  output logic             irq,
  output logic             rx_dma_req,
  output logic             tx_dma_req,
  output logic             tx_halt,
  output logic             special_char_hit
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [ufc_pkg::IRQ_W-1:0]       irq_mask;
  logic [ufc_pkg::IRQ_W-1:0]       raw_status;
  logic [ufc_pkg::IRQ_W-1:0]       masked_interrupt_status;
  logic [ufc_pkg::IRQ_W-1:0]       irq_set;
  logic [ufc_pkg::IRQ_W-1:0]       irq_clr;
  logic [ufc_pkg::DMA_CTRL_W-1:0]  dma_control;
  logic [ufc_pkg::FLOW_CTRL_W-1:0] soft_flow_control;
  logic [ufc_pkg::CHAR_W-1:0]      resume_char1;
  logic [ufc_pkg::CHAR_W-1:0]      resume_char2;
  logic [ufc_pkg::CHAR_W-1:0]      pause_char1;
  logic [ufc_pkg::CHAR_W-1:0]      pause_char2;
  logic                            pause_pending;
  logic                            setup_phase;
  logic                            wr_en;
  logic                            addr_hit;
  logic [31:0]                     next_prdata;
  logic                            soft_flow_enable;
  logic [1:0]                      rx_flow_char_select;
  logic [1:0]                      tx_flow_char_select;
  logic                            any_char_resumes;
  logic                            special_char_detect_enable;
  logic                            rx_dma_enable;
  logic                            tx_dma_enable;
  logic                            rx_dma_stop_on_error;
  logic                            error_irq;
  logic                            rx_dma_want_gated;
  logic                            rx_pause_hit;
  logic                            tx_pause_hit;
  logic                            resume_hit;
  logic                            special_match;

  // ---------------------------------------------------------------
  // Character match against a selected set
  // ---------------------------------------------------------------
  // Select bit 0 picks set one, bit 1 set two, both picks both
  function automatic logic char_match(input logic [7:0] ch,
                                      input logic [1:0] sel,
                                      input logic [7:0] c1,
                                      input logic [7:0] c2);
    char_match = (sel[0] && (ch == c1)) || (sel[1] && (ch == c2));
  endfunction : char_match

  // ---------------------------------------------------------------
  // Field aliases
  // ---------------------------------------------------------------
  // Control bits steering the flow and DMA logic
  assign soft_flow_enable           = soft_flow_control[ufc_pkg::BIT_FLOW_EN];
  assign rx_flow_char_select        = soft_flow_control[ufc_pkg::POS_RX_SEL_LO +: 2];
  assign tx_flow_char_select        = soft_flow_control[ufc_pkg::POS_TX_SEL_LO +: 2];
  assign any_char_resumes           = soft_flow_control[ufc_pkg::BIT_ANY_RESUME];
  assign special_char_detect_enable = soft_flow_control[ufc_pkg::BIT_SPECIAL_EN];
  assign rx_dma_enable              = dma_control[ufc_pkg::BIT_RX_DMA_EN];
  assign tx_dma_enable              = dma_control[ufc_pkg::BIT_TX_DMA_EN];
  assign rx_dma_stop_on_error       = dma_control[ufc_pkg::BIT_DMA_STOP_ER];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Setup phase loads read data; access phase answers in one cycle
  assign setup_phase = psel && !penable;
  assign wr_en       = psel && penable && pready && pwrite && !pslverr;

  // Address map and read mux
  always_comb begin
    addr_hit    = 1'b1;
    next_prdata = 32'h0000_0000;
    if (paddr == ufc_pkg::OFS_MASK) begin
      next_prdata[ufc_pkg::IRQ_W-1:0] = irq_mask;
    end else if (paddr == ufc_pkg::OFS_RAW_STATUS) begin
      next_prdata[ufc_pkg::IRQ_W-1:0] = raw_status;
    end else if (paddr == ufc_pkg::OFS_MASKED_STATUS) begin
      next_prdata[ufc_pkg::IRQ_W-1:0] = masked_interrupt_status;
    end else if (paddr == ufc_pkg::OFS_INT_CLEAR) begin
      next_prdata = 32'h0000_0000;                                // Write-only
    end else if (paddr == ufc_pkg::OFS_DMA_CONTROL) begin
      next_prdata[ufc_pkg::DMA_CTRL_W-1:0] = dma_control;
    end else if (paddr == ufc_pkg::OFS_SOFT_FLOW) begin
      next_prdata[ufc_pkg::FLOW_CTRL_W-1:0] = soft_flow_control;
    end else if (paddr == ufc_pkg::OFS_RESUME_CHAR1) begin
      next_prdata[ufc_pkg::CHAR_W-1:0] = resume_char1;
    end else if (paddr == ufc_pkg::OFS_RESUME_CHAR2) begin
      next_prdata[ufc_pkg::CHAR_W-1:0] = resume_char2;
    end else if (paddr == ufc_pkg::OFS_PAUSE_CHAR1) begin
      next_prdata[ufc_pkg::CHAR_W-1:0] = pause_char1;
    end else if (paddr == ufc_pkg::OFS_PAUSE_CHAR2) begin
      next_prdata[ufc_pkg::CHAR_W-1:0] = pause_char2;
    end else if (paddr == ufc_pkg::OFS_FLOW_STATUS) begin
      next_prdata[1:0] = {pause_pending, tx_halt};
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !addr_hit;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= ufc_pkg::RST_IRQ;
    end else if (wr_en && paddr == ufc_pkg::OFS_MASK) begin
      irq_mask <= pwdata[ufc_pkg::IRQ_W-1:0] & ufc_pkg::IRQ_IMPL_BITS;
    end
  end

  // DMA control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_control <= ufc_pkg::RST_DMA_CTRL;
    end else if (wr_en && paddr == ufc_pkg::OFS_DMA_CONTROL) begin
      dma_control <= pwdata[ufc_pkg::DMA_CTRL_W-1:0] & ufc_pkg::DMA_CTRL_IMPL;
    end
  end

  // Soft flow control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_flow_control <= ufc_pkg::RST_FLOW_CTRL;
    end else if (wr_en && paddr == ufc_pkg::OFS_SOFT_FLOW) begin
      soft_flow_control <= pwdata[ufc_pkg::FLOW_CTRL_W-1:0];
    end
  end

  // Resume and pause character registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_char1 <= ufc_pkg::RST_CHAR;
      resume_char2 <= ufc_pkg::RST_CHAR;
      pause_char1  <= ufc_pkg::RST_CHAR;
      pause_char2  <= ufc_pkg::RST_CHAR;
    end else if (wr_en) begin
      if (paddr == ufc_pkg::OFS_RESUME_CHAR1) begin
        resume_char1 <= pwdata[ufc_pkg::CHAR_W-1:0];
      end else if (paddr == ufc_pkg::OFS_RESUME_CHAR2) begin
        resume_char2 <= pwdata[ufc_pkg::CHAR_W-1:0];
      end else if (paddr == ufc_pkg::OFS_PAUSE_CHAR1) begin
        pause_char1 <= pwdata[ufc_pkg::CHAR_W-1:0];
      end else if (paddr == ufc_pkg::OFS_PAUSE_CHAR2) begin
        pause_char2 <= pwdata[ufc_pkg::CHAR_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Character recognition
  // ---------------------------------------------------------------
  // Pause seen on the receive side raises the pause interrupt
  assign rx_pause_hit = rx_char_valid && soft_flow_enable &&
                        char_match(rx_char, rx_flow_char_select, pause_char1, pause_char2);

  // Pause seen for the transmit side halts our transmitter
  assign tx_pause_hit = rx_char_valid && soft_flow_enable &&
                        char_match(rx_char, tx_flow_char_select, pause_char1, pause_char2);

  // Valid resume, if not a selected pause: any char, or one of the selected resume values
  assign resume_hit = rx_char_valid && soft_flow_enable && !tx_pause_hit &&
                      (any_char_resumes ||
                       char_match(rx_char, tx_flow_char_select, resume_char1, resume_char2));

  // Special detection flags any programmed flow character
  assign special_match = rx_char_valid && special_char_detect_enable &&
                         (char_match(rx_char, 2'b11, pause_char1, pause_char2) ||
                          char_match(rx_char, 2'b11, resume_char1, resume_char2));

  // Special character pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_char_hit <= 1'b0;
    end else begin
      special_char_hit <= special_match;
    end
  end

  // ---------------------------------------------------------------
  // Transmit halt
  // ---------------------------------------------------------------
  // Pause waits for the current character to finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_pending <= 1'b0;
    end else if (!soft_flow_enable || tx_flow_char_select == 2'b00 || resume_hit) begin
      pause_pending <= 1'b0;
    end else if (tx_pause_hit) begin
      pause_pending <= 1'b1;
    end else if (tx_char_boundary) begin
      pause_pending <= 1'b0;
    end
  end

  // Halt level seen by the transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_halt <= 1'b0;
    end else if (!soft_flow_enable || tx_flow_char_select == 2'b00 || resume_hit) begin
      tx_halt <= 1'b0;
    end else if (pause_pending && tx_char_boundary) begin
      tx_halt <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  // Event vector in status bit order
  always_comb begin
    irq_set                         = ufc_pkg::RST_IRQ;
    irq_set[ufc_pkg::BIT_CTS]       = evt_cts;
    irq_set[ufc_pkg::BIT_RX]        = evt_rx;
    irq_set[ufc_pkg::BIT_TX]        = evt_tx;
    irq_set[ufc_pkg::BIT_RX_TMO]    = evt_rx_timeout;
    irq_set[ufc_pkg::BIT_FRAMING]   = evt_framing_err;
    irq_set[ufc_pkg::BIT_PARITY]    = evt_parity_err;
    irq_set[ufc_pkg::BIT_BREAK]     = evt_break_err;
    irq_set[ufc_pkg::BIT_OVERRUN]   = evt_overrun_err;
    irq_set[ufc_pkg::BIT_PAUSE]     = rx_pause_hit;
    irq_set[ufc_pkg::BIT_TX_EMPTY]  = evt_tx_fifo_empty;
  end

  // Clear vector from a write of ones; zeros do nothing
  assign irq_clr = (wr_en && paddr == ufc_pkg::OFS_INT_CLEAR) ?
                   (pwdata[ufc_pkg::IRQ_W-1:0] & ufc_pkg::IRQ_IMPL_BITS) : ufc_pkg::RST_IRQ;

  // Sticky raw flags; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_status <= ufc_pkg::RST_IRQ;
    end else begin
      raw_status <= (raw_status & ~irq_clr) | irq_set;
    end
  end

  // Masked view of the raw flags
  assign masked_interrupt_status = raw_status & irq_mask;

  // Interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |masked_interrupt_status;
    end
  end

  // ---------------------------------------------------------------
  // DMA requests
  // ---------------------------------------------------------------
  // Any masked receive error blocks receive DMA when asked to
  assign error_irq = masked_interrupt_status[ufc_pkg::BIT_FRAMING] |
                     masked_interrupt_status[ufc_pkg::BIT_PARITY] |
                     masked_interrupt_status[ufc_pkg::BIT_BREAK] |
                     masked_interrupt_status[ufc_pkg::BIT_OVERRUN];
  assign rx_dma_want_gated = rx_dma_want && !(rx_dma_stop_on_error && error_irq);

  // Receive request line
  ufc_dma_req u_rx_dma (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (rx_dma_enable),
    .want    (rx_dma_want_gated),
    .ack     (rx_dma_ack),
    .req     (rx_dma_req)
  );

  // Transmit request line
  ufc_dma_req u_tx_dma (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (tx_dma_enable),
    .want    (tx_dma_want),
    .ack     (tx_dma_ack),
    .req     (tx_dma_req)
  );

endmodule : ufc_top
